// ### hdl/fault_cfg_if.sv
interface fault_cfg_if;
  logic       wr_stb;
  logic [7:0] wr_code;
  logic [7:0] wr_data;
  logic       default_load;
  logic       default_from_strap;
  logic [7:0] nvm_uv_threshold;
  logic [7:0] nvm_uv_response;
  logic [7:0] nvm_valley_limit;
  logic [3:0] strap_valley_code;
  logic [1:0] uv_threshold_code;
  logic       uv_restart;
  logic [1:0] uv_delay_code;
  logic [3:0] valley_limit_code;

  modport store (
    input  wr_stb, wr_code, wr_data, default_load, default_from_strap,
    input  nvm_uv_threshold, nvm_uv_response, nvm_valley_limit, strap_valley_code,
    output uv_threshold_code, uv_restart, uv_delay_code, valley_limit_code
  );

  modport core (
    output wr_stb, wr_code, wr_data, default_load, default_from_strap,
    output nvm_uv_threshold, nvm_uv_response, nvm_valley_limit, strap_valley_code,
    input  uv_threshold_code, uv_restart, uv_delay_code, valley_limit_code
  );
endinterface : fault_cfg_if

// ### hdl/fault_cfg_regs.sv
module fault_cfg_regs (
  input  wire logic  clk_sys_in,
  input  wire logic  rst_n_in,
  input  wire logic  ce_in,
  fault_cfg_if.store cfg
);

  // ------------------------------------------------------------------
  // Threshold select: only bits 1:0 are stored
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cfg.uv_threshold_code <= uv_oc_pkg::UV_THR_RESET;
    end else if (ce_in) begin
      if (cfg.wr_stb && cfg.wr_code == uv_oc_pkg::CMD_UV_THRESHOLD) begin
        cfg.uv_threshold_code <=
          cfg.wr_data[uv_oc_pkg::UV_THR_LSB +: uv_oc_pkg::UV_THR_W];
      end else if (cfg.default_load) begin
        cfg.uv_threshold_code <=
          cfg.nvm_uv_threshold[uv_oc_pkg::UV_THR_LSB +: uv_oc_pkg::UV_THR_W];
      end
    end
  end

  // ------------------------------------------------------------------
  // Response control: restart bit and delay field
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cfg.uv_restart    <= uv_oc_pkg::RESTART_RESET;
      cfg.uv_delay_code <= uv_oc_pkg::RSP_DELAY_RESET;
    end else if (ce_in) begin
      if (cfg.wr_stb && cfg.wr_code == uv_oc_pkg::CMD_UV_RESPONSE) begin
        cfg.uv_restart    <= cfg.wr_data[uv_oc_pkg::RSP_RESTART_BIT];
        cfg.uv_delay_code <= cfg.wr_data[uv_oc_pkg::RSP_DELAY_LSB +: uv_oc_pkg::RSP_DELAY_W];
      end else if (cfg.default_load) begin
        cfg.uv_restart    <= cfg.nvm_uv_response[uv_oc_pkg::RSP_RESTART_BIT];
        cfg.uv_delay_code <=
          cfg.nvm_uv_response[uv_oc_pkg::RSP_DELAY_LSB +: uv_oc_pkg::RSP_DELAY_W];
      end
    end
  end

  // ------------------------------------------------------------------
  // Valley limit: default from storage or strap, writable while running
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cfg.valley_limit_code <= uv_oc_pkg::OCL_RESET;
    end else if (ce_in) begin
      if (cfg.wr_stb && cfg.wr_code == uv_oc_pkg::CMD_VALLEY_LIMIT) begin
        cfg.valley_limit_code <=
          cfg.wr_data[uv_oc_pkg::OCL_LSB +: uv_oc_pkg::OCL_W];
      end else if (cfg.default_load) begin
        cfg.valley_limit_code <= cfg.default_from_strap ? cfg.strap_valley_code
                               : cfg.nvm_valley_limit[uv_oc_pkg::OCL_LSB +: uv_oc_pkg::OCL_W];
      end
    end
  end

endmodule : fault_cfg_regs

// ### hdl/uv_oc_fault_ctrl.sv
// Behaviour
// - The three config registers are byte-written and byte-read at codes 44h, 45h, 46h.
// - Undervoltage trip point sits an offset below the latest commanded setpoint.
// - Threshold code 00 gives -150, 01/10 give -200, 11 gives -300 mV.
// - Undervoltage detection stays off until the soft-start ramp has finished.
// - A detected undervoltage sets the flag in the status register at 7Ah.
// - Detection starts the delay timer; recovery above threshold clears it to zero.
// - A fresh fall below threshold restarts the delay count from zero.
// - Delay field offers 2, 16, 64 and 256 us choices.
// - Restart bit 0 latches conversion off until power cycle or enable toggle.
// - Restart bit 1 retries conversion 56 ms after the fault, without limit.
// - Selected limit is compared to valley current; exceeding it flags overcurrent.
// - Valley codes 0000b..1010b give 10,12,15,19,20,25,26,30,33,35,39 A.
// - Valley codes 1011b through 1111b all give 40 A.
// - Valley default loads from storage or strap and may change while running.
// - Reserved bits read zero and ignore writes.
// - No alert output exists; the host polls status.
// - Undervoltage is measured on the differential remote-sense voltage.
module uv_oc_fault_ctrl #(
  parameter int unsigned RETRY_CYCLES = uv_oc_pkg::RETRY_DELAY_CYC
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  input  wire logic [7:0]  cmd_code_in,
  input  wire logic        wr_en_in,
  input  wire logic [7:0]  wr_data_in,
  input  wire logic        rd_en_in,
  input  wire logic        default_load_in,
  input  wire logic        default_from_strap_in,
  input  wire logic [7:0]  nvm_uv_threshold_in,
  input  wire logic [7:0]  nvm_uv_response_in,
  input  wire logic [7:0]  nvm_valley_limit_in,
  input  wire logic [3:0]  strap_valley_code_in,
  input  wire logic        voltage_id_set_command_in,
  input  wire logic [11:0] voltage_id_setpoint_mv_in,
  input  wire logic        output_setpoint_command_in,
  input  wire logic [11:0] output_setpoint_mv_in,
  input  wire logic [11:0] positive_remote_sense_in,
  input  wire logic [11:0] negative_remote_sense_in,
  input  wire logic        soft_start_done_in,
  input  wire logic        enable_in,
  input  wire logic [5:0]  valley_current_a_in,
  output logic [7:0]       rd_data_out,
  output logic             rd_valid_out,
  output logic             conversion_enable_out,
  output logic             tracking_undervoltage_flag_out,
  output logic             overcurrent_flag_out,
  output logic             uv_fault_latched_out
);

  // ------------------------------------------------------------------
  // Configuration store
  // ------------------------------------------------------------------
  fault_cfg_if cfg ();

  // Command port and default sources handed to the store
  assign cfg.wr_stb             = wr_en_in;
  assign cfg.wr_code            = cmd_code_in;
  assign cfg.wr_data            = wr_data_in;
  assign cfg.default_load       = default_load_in;
  assign cfg.default_from_strap = default_from_strap_in;
  assign cfg.nvm_uv_threshold   = nvm_uv_threshold_in;
  assign cfg.nvm_uv_response    = nvm_uv_response_in;
  assign cfg.nvm_valley_limit   = nvm_valley_limit_in;
  assign cfg.strap_valley_code  = strap_valley_code_in;

  fault_cfg_regs u_regs (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .cfg        (cfg.store)
  );

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  uv_oc_pkg::fault_state_t     state_r;
  uv_oc_pkg::fault_state_t     state_nxt;
  logic [11:0]                 setpoint_mv_r;
  logic [uv_oc_pkg::CNT_W-1:0] count_r;
  logic [uv_oc_pkg::CNT_W-1:0] count_nxt;
  logic [uv_oc_pkg::CNT_W-1:0] delay_cycles;
  logic [uv_oc_pkg::CNT_W-1:0] retry_cycles;
  logic [13:0]                 uv_offset_mv;
  logic signed [13:0]          sense_diff_mv;
  logic signed [13:0]          uv_trip_mv;
  logic                        below_trip;
  logic                        detect_armed;
  logic                        uv_detect;
  logic                        status_clear;
  logic [5:0]                  valley_limit_a;
  logic [15:0]                 limit_onehot;
  logic                        enable_d_r;
  logic [7:0]                  rd_data_nxt;

  assign retry_cycles = uv_oc_pkg::CNT_W'(RETRY_CYCLES);

  // ------------------------------------------------------------------
  // Setpoint tracking
  // ------------------------------------------------------------------

  // Latest setpoint from either source; voltage ID wins a tie
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      setpoint_mv_r <= 12'h000;
    end else if (ce_in) begin
      if (voltage_id_set_command_in) begin
        setpoint_mv_r <= voltage_id_setpoint_mv_in;
      end else if (output_setpoint_command_in) begin
        setpoint_mv_r <= output_setpoint_mv_in;
      end
    end
  end

  // ------------------------------------------------------------------
  // Undervoltage comparator
  // ------------------------------------------------------------------

  // Offset decode from the threshold code
  always_comb begin
    case (cfg.uv_threshold_code)
      2'h0:    uv_offset_mv = uv_oc_pkg::UV_OFS_150_MV;
      2'h1:    uv_offset_mv = uv_oc_pkg::UV_OFS_200_MV;
      2'h2:    uv_offset_mv = uv_oc_pkg::UV_OFS_200_MV;
      2'h3:    uv_offset_mv = uv_oc_pkg::UV_OFS_300_MV;
      default: uv_offset_mv = uv_oc_pkg::UV_OFS_150_MV;
    endcase
  end

  // Differential sense against a trip point below the setpoint
  assign sense_diff_mv = $signed({2'b00, positive_remote_sense_in})
                       - $signed({2'b00, negative_remote_sense_in});
  assign uv_trip_mv    = $signed({2'b00, setpoint_mv_r}) - $signed(uv_offset_mv);
  assign below_trip    = sense_diff_mv < uv_trip_mv;

  // Detection only while converting and after soft-start
  assign detect_armed = soft_start_done_in
                     && (state_r == uv_oc_pkg::ST_RUN);
  assign uv_detect    = detect_armed && below_trip;

  // ------------------------------------------------------------------
  // Response delay decode
  // ------------------------------------------------------------------

  // Ascending code to delay mapping
  always_comb begin
    case (cfg.uv_delay_code)
      2'h0:    delay_cycles = uv_oc_pkg::DLY_2US_CYC;
      2'h1:    delay_cycles = uv_oc_pkg::DLY_16US_CYC;
      2'h2:    delay_cycles = uv_oc_pkg::DLY_64US_CYC;
      2'h3:    delay_cycles = uv_oc_pkg::DLY_256US_CYC;
      default: delay_cycles = uv_oc_pkg::DLY_2US_CYC;
    endcase
  end

  // ------------------------------------------------------------------
  // Fault sequencer
  // ------------------------------------------------------------------

  // Next state and shared counter
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    case (state_r)
      uv_oc_pkg::ST_OFF: begin
        count_nxt = uv_oc_pkg::CNT_ZERO;
        if (enable_in && !enable_d_r) begin
          state_nxt = uv_oc_pkg::ST_RUN;
        end
      end
      uv_oc_pkg::ST_RUN: begin
        count_nxt = uv_oc_pkg::CNT_ZERO;
        if (!enable_in) begin
          state_nxt = uv_oc_pkg::ST_OFF;
        end else if (uv_detect) begin
          state_nxt = uv_oc_pkg::ST_QUALIFY;
          count_nxt = uv_oc_pkg::CNT_ONE;
        end
      end
      uv_oc_pkg::ST_QUALIFY: begin
        if (!enable_in) begin
          state_nxt = uv_oc_pkg::ST_OFF;
          count_nxt = uv_oc_pkg::CNT_ZERO;
        end else if (!below_trip) begin
          state_nxt = uv_oc_pkg::ST_RUN;
          count_nxt = uv_oc_pkg::CNT_ZERO;
        end else if (count_r >= delay_cycles) begin
          count_nxt = uv_oc_pkg::CNT_ZERO;
          if (cfg.uv_restart) begin
            state_nxt = uv_oc_pkg::ST_RETRY;
          end else begin
            state_nxt = uv_oc_pkg::ST_LATCHED;
          end
        end else begin
          count_nxt = count_r + uv_oc_pkg::CNT_ONE;
        end
      end
      uv_oc_pkg::ST_LATCHED: begin
        count_nxt = uv_oc_pkg::CNT_ZERO;
        if (!enable_in) begin
          state_nxt = uv_oc_pkg::ST_OFF;
        end
      end
      uv_oc_pkg::ST_RETRY: begin
        if (!enable_in) begin
          state_nxt = uv_oc_pkg::ST_OFF;
          count_nxt = uv_oc_pkg::CNT_ZERO;
        end else if (count_r >= retry_cycles - uv_oc_pkg::CNT_ONE) begin
          state_nxt = uv_oc_pkg::ST_RUN;
          count_nxt = uv_oc_pkg::CNT_ZERO;
        end else begin
          count_nxt = count_r + uv_oc_pkg::CNT_ONE;
        end
      end
      default: begin
        state_nxt = uv_oc_pkg::ST_OFF;
        count_nxt = uv_oc_pkg::CNT_ZERO;
      end
    endcase
  end

  // State and counter registers
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_r <= uv_oc_pkg::ST_OFF;
      count_r <= uv_oc_pkg::CNT_ZERO;
    end else if (ce_in) begin
      state_r <= state_nxt;
      count_r <= count_nxt;
    end
  end

  // Enable history for toggle detection
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      enable_d_r <= 1'b0;
    end else if (ce_in) begin
      enable_d_r <= enable_in;
    end
  end

  // Conversion enable and latch-off indication
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      conversion_enable_out <= 1'b0;
      uv_fault_latched_out  <= 1'b0;
    end else if (ce_in) begin
      conversion_enable_out <= (state_nxt == uv_oc_pkg::ST_RUN)
                            || (state_nxt == uv_oc_pkg::ST_QUALIFY);
      uv_fault_latched_out  <= (state_nxt == uv_oc_pkg::ST_LATCHED);
    end
  end

  // ------------------------------------------------------------------
  // Status flag
  // ------------------------------------------------------------------

  // Write one to clear at the status code
  assign status_clear = wr_en_in && (cmd_code_in == uv_oc_pkg::CMD_VOUT_STATUS)
                     && wr_data_in[uv_oc_pkg::STATUS_UVF_BIT];

  // Sticky flag, a new detection wins over a clear; polled only
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      tracking_undervoltage_flag_out <= 1'b0;
    end else if (ce_in) begin
      if (uv_detect) begin
        tracking_undervoltage_flag_out <= 1'b1;
      end else if (status_clear) begin
        tracking_undervoltage_flag_out <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Valley overcurrent comparator
  // ------------------------------------------------------------------

  // One-hot select of table entries
  for (genvar i = 0; i < 16; i++) begin : g_ocl
    assign limit_onehot[i] = (cfg.valley_limit_code == 4'(i));
  end

  // Table lookup of the selected limit
  always_comb begin
    valley_limit_a = uv_oc_pkg::OCL_TABLE_A[0];
    for (int j = 0; j < 16; j++) begin
      if (limit_onehot[j]) begin
        valley_limit_a = uv_oc_pkg::OCL_TABLE_A[j];
      end
    end
  end

  // Level flag while valley current exceeds the limit
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      overcurrent_flag_out <= 1'b0;
    end else if (ce_in) begin
      overcurrent_flag_out <= valley_current_a_in > valley_limit_a;
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------

  // Byte read mux, reserved bits zero
  always_comb begin
    rd_data_nxt = uv_oc_pkg::BYTE_ZERO;
    case (cmd_code_in)
      uv_oc_pkg::CMD_UV_THRESHOLD: begin
        rd_data_nxt[uv_oc_pkg::UV_THR_LSB +: uv_oc_pkg::UV_THR_W] =
          cfg.uv_threshold_code;
      end
      uv_oc_pkg::CMD_UV_RESPONSE: begin
        rd_data_nxt[uv_oc_pkg::RSP_RESTART_BIT] = cfg.uv_restart;
        rd_data_nxt[uv_oc_pkg::RSP_DELAY_LSB +: uv_oc_pkg::RSP_DELAY_W] = cfg.uv_delay_code;
      end
      uv_oc_pkg::CMD_VALLEY_LIMIT: begin
        rd_data_nxt[uv_oc_pkg::OCL_LSB +: uv_oc_pkg::OCL_W] =
          cfg.valley_limit_code;
      end
      uv_oc_pkg::CMD_VOUT_STATUS: begin
        rd_data_nxt[uv_oc_pkg::STATUS_UVF_BIT] = tracking_undervoltage_flag_out;
      end
      default: begin
        rd_data_nxt = uv_oc_pkg::BYTE_ZERO;
      end
    endcase
  end

  // Registered read answer
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rd_data_out  <= uv_oc_pkg::BYTE_ZERO;
      rd_valid_out <= 1'b0;
    end else if (ce_in) begin
      rd_valid_out <= rd_en_in;
      if (rd_en_in) begin
        rd_data_out <= rd_data_nxt;
      end
    end
  end

endmodule : uv_oc_fault_ctrl

// ### hdl/uv_oc_pkg.sv
package uv_oc_pkg;

  // ------------------------------------------------------------------
  // Command codes
  // ------------------------------------------------------------------
  localparam logic [7:0] CMD_UV_THRESHOLD = 8'h44;
  localparam logic [7:0] CMD_UV_RESPONSE  = 8'h45;
  localparam logic [7:0] CMD_VALLEY_LIMIT = 8'h46;
  localparam logic [7:0] CMD_VOUT_STATUS  = 8'h7A;

  // ------------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------------
  localparam int UV_THR_LSB      = 0;
  localparam int UV_THR_W        = 2;
  localparam int RSP_DELAY_LSB   = 0;
  localparam int RSP_DELAY_W     = 2;
  localparam int RSP_RESTART_BIT = 3;
  localparam int OCL_LSB         = 0;
  localparam int OCL_W           = 4;
  localparam int STATUS_UVF_BIT  = 4;

  // ------------------------------------------------------------------
  // Reset values of the fields before defaults are loaded
  // ------------------------------------------------------------------
  localparam logic [1:0] UV_THR_RESET    = 2'h0;
  localparam logic [1:0] RSP_DELAY_RESET = 2'h0;
  localparam logic       RESTART_RESET   = 1'b0;
  localparam logic [3:0] OCL_RESET       = 4'h0;
  localparam logic [7:0] BYTE_ZERO       = 8'h00;

  // ------------------------------------------------------------------
  // Undervoltage offsets below the setpoint, in mV
  // ------------------------------------------------------------------
  localparam logic [13:0] UV_OFS_150_MV = 14'h0096;
  localparam logic [13:0] UV_OFS_200_MV = 14'h00C8;
  localparam logic [13:0] UV_OFS_300_MV = 14'h012C;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;
  localparam int DLY_2US_NS     = 2000;
  localparam int DLY_16US_NS    = 16000;
  localparam int DLY_64US_NS    = 64000;
  localparam int DLY_256US_NS   = 256000;
  localparam int RETRY_DELAY_NS = 56000000;
  localparam int CNT_W          = 20;

  // Least times round up to whole cycles
  localparam logic [CNT_W-1:0] DLY_2US_CYC   =
    CNT_W'((DLY_2US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] DLY_16US_CYC  =
    CNT_W'((DLY_16US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] DLY_64US_CYC  =
    CNT_W'((DLY_64US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] DLY_256US_CYC =
    CNT_W'((DLY_256US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int RETRY_DELAY_CYC = (RETRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 20'h00001;

  // ------------------------------------------------------------------
  // Valley limit table in amps, indexed by code
  // ------------------------------------------------------------------
  localparam logic [5:0] OCL_TABLE_A [16] = '{
    6'h0A, 6'h0C, 6'h0F, 6'h13, 6'h14, 6'h19, 6'h1A, 6'h1E,
    6'h21, 6'h23, 6'h27, 6'h28, 6'h28, 6'h28, 6'h28, 6'h28
  };

  // ------------------------------------------------------------------
  // Fault sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_RUN     = 3'b001,
    ST_QUALIFY = 3'b010,
    ST_LATCHED = 3'b011,
    ST_RETRY   = 3'b100
  } fault_state_t;

endpackage : uv_oc_pkg

// ### tb/fault_host.sv
module fault_host (
  input  wire logic       clk_sys_in,
  input  wire logic [7:0] rd_data_out,
  input  wire logic       rd_valid_out,
  output logic      [7:0] cmd_code_in,
  output logic            wr_en_in,
  output logic      [7:0] wr_data_in,
  output logic            rd_en_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bus idle at time zero
  initial {wr_en_in, rd_en_in, cmd_code_in, wr_data_in} = '0;
  // Single-byte write; released lines show inverted values
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    @(posedge clk_sys_in);
    #1;
    {cmd_code_in, wr_data_in, wr_en_in} = {c, d, 1'b1};
    @(posedge clk_sys_in);
    #1;
    {cmd_code_in, wr_data_in, wr_en_in} = {~c, ~d, 1'b0};
  endtask : wr
  // Single-byte read; answer taken after the edge that accepts it
  task automatic rd(input logic [7:0] c, output logic [7:0] d, output logic v);
    @(posedge clk_sys_in);
    #1;
    {cmd_code_in, rd_en_in} = {c, 1'b1};
    @(posedge clk_sys_in);
    #1;
    {cmd_code_in, rd_en_in} = {~c, 1'b0};
    {d, v} = {rd_data_out, rd_valid_out};
  endtask : rd
endmodule : fault_host

// ### tb/output_uv_and_valley_oc_fault_config_test.sv
module output_uv_and_valley_oc_fault_config_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_in, rst_n_in, ce_in, wr_en_in, rd_en_in, rd_valid_out, vv;
  logic        default_load_in, default_from_strap_in, soft_start_done_in, enable_in;
  logic        voltage_id_set_command_in, output_setpoint_command_in, uv_fault_latched_out;
  logic        conversion_enable_out, tracking_undervoltage_flag_out, overcurrent_flag_out;
  logic [7:0]  cmd_code_in, wr_data_in, rd_data_out, rv;
  logic [7:0]  nvm_uv_threshold_in, nvm_uv_response_in, nvm_valley_limit_in;
  logic [11:0] voltage_id_setpoint_mv_in, output_setpoint_mv_in;
  logic [11:0] positive_remote_sense_in, negative_remote_sense_in;
  logic [3:0]  strap_valley_code_in;
  logic [5:0]  valley_current_a_in;
  logic [5:0]  lim [16] = '{6'h0A, 6'h0C, 6'h0F, 6'h13, 6'h14, 6'h19, 6'h1A, 6'h1E,
                            6'h21, 6'h23, 6'h27, 6'h28, 6'h28, 6'h28, 6'h28, 6'h28};
  logic [7:0]  rsv [3] = '{8'h03, 8'h0B, 8'h0F};
  int          mismatches = 0;
  int          num_checks = 0;

  fault_host u_fault_host (.*);
  uv_oc_fault_ctrl #(.RETRY_CYCLES(50)) u_uv_oc_fault_ctrl (.*);

  // Compare and count
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Read a register and check valid and data
  task automatic rchk(input logic [7:0] c, input logic [7:0] e);
    u_fault_host.rd(c, rv, vv);
    chk("rd_valid_out", 8'h01, 8'(vv));
    chk("rd_data_out", e, rv);
  endtask : rchk
  // Wait whole cycles, land just after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : cyc
  // Counts and verdict
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // 10 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  // Hang guard
  initial begin
    #1000000;
    mismatches++;
    conclude();
  end
  // Test sequence
  initial begin
    {rst_n_in, default_load_in, soft_start_done_in, enable_in, valley_current_a_in} = '0;
    {voltage_id_set_command_in, output_setpoint_command_in} = '0;
    {voltage_id_setpoint_mv_in, output_setpoint_mv_in, negative_remote_sense_in} = '0;
    {ce_in, default_from_strap_in, strap_valley_code_in} = {2'b11, 4'h9};
    {nvm_uv_threshold_in, nvm_uv_response_in, nvm_valley_limit_in} = {8'hFF, 8'hFF, 8'h05};
    positive_remote_sense_in = 12'h3E8;
    cyc(16);
    rst_n_in = 1'b1;
    for (int i = 0; i < 3; i++) begin
      rchk(8'h44 + 8'(i), 8'h00);
      u_fault_host.wr(8'h44 + 8'(i), 8'hFF);
      rchk(8'h44 + 8'(i), rsv[i]);
    end
    ce_in = 1'b0;
    u_fault_host.wr(8'h44, 8'h01);
    ce_in = 1'b1;
    rchk(8'h44, 8'h03);
    rchk(8'h47, 8'h00);
    default_load_in = 1'b1;
    cyc(1);
    default_load_in = 1'b0;
    rchk(8'h46, 8'h09);
    $display("test registers done");
    for (int c = 0; c < 16; c++) begin
      u_fault_host.wr(8'h46, 8'(c));
      valley_current_a_in = lim[c];
      cyc(2);
      chk("oc_at_limit", 8'h00, 8'(overcurrent_flag_out));
      valley_current_a_in = lim[c] + 6'h01;
      cyc(2);
      chk("oc_above", 8'h01, 8'(overcurrent_flag_out));
    end
    $display("test valley done");
    valley_current_a_in = 6'h00;
    output_setpoint_mv_in = 12'h3E8;
    output_setpoint_command_in = 1'b1;
    cyc(1);
    output_setpoint_command_in = 1'b0;
    u_fault_host.wr(8'h44, 8'h00);
    u_fault_host.wr(8'h45, 8'h00);
    enable_in = 1'b1;
    positive_remote_sense_in = 12'h351;  // 849 mV, just under the trip
    cyc(5);
    chk("uv_early", 8'h00, 8'(tracking_undervoltage_flag_out));
    soft_start_done_in = 1'b1;
    cyc(12);
    positive_remote_sense_in = 12'h352;  // Back at the trip, not under it
    cyc(3);
    positive_remote_sense_in = 12'h351;
    cyc(16);
    chk("conv_requalify", 8'h01, 8'(conversion_enable_out));
    cyc(10);
    chk("conv_latched", 8'h00, 8'(conversion_enable_out));
    chk("latched", 8'h01, 8'(uv_fault_latched_out));
    u_fault_host.rd(8'h7A, rv, vv);
    chk("status", 8'h10, rv & 8'h10);
    positive_remote_sense_in = 12'h3E8;
    u_fault_host.wr(8'h7A, 8'h10);
    chk("uv_cleared", 8'h00, 8'(tracking_undervoltage_flag_out));
    enable_in = 1'b0;
    cyc(2);
    enable_in = 1'b1;
    cyc(2);
    chk("conv_reenabled", 8'h01, 8'(conversion_enable_out));
    u_fault_host.wr(8'h44, 8'h03);
    u_fault_host.wr(8'h45, 8'h08);
    voltage_id_setpoint_mv_in = 12'h4B0;
    voltage_id_set_command_in = 1'b1;
    cyc(1);
    voltage_id_set_command_in = 1'b0;
    negative_remote_sense_in = 12'h064;
    positive_remote_sense_in = 12'h3E7;  // 899 mV across the sense pair
    cyc(25);
    chk("conv_retry_off", 8'h00, 8'(conversion_enable_out));
    positive_remote_sense_in = 12'h4B0;
    cyc(55);
    chk("conv_retry_on", 8'h01, 8'(conversion_enable_out));
    u_fault_host.wr(8'h45, 8'h09);
    positive_remote_sense_in = 12'h3E7;
    cyc(100);
    chk("conv_delay16", 8'h01, 8'(conversion_enable_out));
    cyc(70);
    chk("conv_delay16_off", 8'h00, 8'(conversion_enable_out));
    $display("test undervoltage done");
    conclude();
  end
endmodule : output_uv_and_valley_oc_fault_config_test

// ### tb/uv_oc_asserts.sv
module uv_oc_asserts (
  input wire logic       clk_sys_in,
  input wire logic       rst_n_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic       rd_en_in,
  input wire logic       soft_start_done_in,
  input wire logic [5:0] valley_current_a_in,
  input wire logic [7:0] rd_data_out,
  input wire logic       rd_valid_out,
  input wire logic       conversion_enable_out,
  input wire logic       tracking_undervoltage_flag_out,
  input wire logic       overcurrent_flag_out,
  input wire logic       uv_fault_latched_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // One clock domain, checks idle during reset
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  a_read_answer: assert property (rd_en_in |=> rd_valid_out)
    else $error("read not answered");
  a_thr_reserved: assert property (rd_en_in && cmd_code_in == 8'h44 |=> rd_data_out[7:2] == 6'h00)
    else $error("threshold reserved bits set");
  a_rsp_reserved: assert property (rd_en_in && cmd_code_in == 8'h45 |=> (rd_data_out & 8'hF4) == 8'h00)
    else $error("response reserved bits set");
  a_lim_reserved: assert property (rd_en_in && cmd_code_in == 8'h46 |=> rd_data_out[7:4] == 4'h0)
    else $error("limit reserved bits set");
  a_oc_ceiling: assert property (valley_current_a_in > 6'h28 |=> overcurrent_flag_out)
    else $error("current above every limit not flagged");
  a_oc_floor: assert property (valley_current_a_in <= 6'h0A |=> !overcurrent_flag_out)
    else $error("current within least limit flagged");
  a_uv_after_ramp: assert property ($rose(tracking_undervoltage_flag_out) |-> $past(soft_start_done_in))
    else $error("undervoltage flagged before ramp end");
  a_latch_off: assert property (uv_fault_latched_out |=> !conversion_enable_out)
    else $error("conversion running while latched off");
endmodule : uv_oc_asserts

bind uv_oc_fault_ctrl uv_oc_asserts u_uv_oc_asserts (.*);
